// ===== shared/ppl_pkg.sv
// package for the pcs link configuration register bank
// assumes a 16-bit register port and a 20 MHz core clock
package ppl_pkg;
  // register addresses on the management port
  localparam logic [11:0] ADDR_TRAIN_LOCK = 12'h485;
  localparam logic [11:0] ADDR_UNLOCK_ERR = 12'h486;
  localparam logic [11:0] ADDR_TX_ILV = 12'h489;
  localparam logic [11:0] ADDR_JABBER = 12'h496;
  localparam logic [11:0] ADDR_TEST_PAT = 12'h497;
  localparam logic [11:0] ADDR_LINK_STATUS = 12'h498;

  // reset values
  localparam logic [15:0] RST_TRAIN_LOCK = 16'h1078;
  localparam logic [15:0] RST_UNLOCK_ERR = 16'h0a05;
  localparam logic [15:0] RST_TX_ILV = 16'h0001;
  localparam logic [15:0] RST_JABBER = 16'h044c;
  localparam logic [15:0] RST_TEST_PAT = 16'h01c0;

  // writable bits; everything else reads as zero
  localparam logic [15:0] WMASK_TRAIN_LOCK = 16'h71ff;
  localparam logic [15:0] WMASK_UNLOCK_ERR = 16'hff1f;
  localparam logic [15:0] WMASK_TX_ILV = 16'h0007;
  localparam logic [15:0] WMASK_JABBER = 16'h07ff;
  localparam logic [15:0] WMASK_TEST_PAT = 16'h03f0;

  // field positions in the training and lock control register
  localparam int FORCE_SLAVE_BIT = 14;
  localparam int DIS_IPG_LOCK_BIT = 13;
  localparam int LINK_CTRL_BIT = 12;
  localparam int FIRST_LOCK_MSB = 8;
  localparam int FIRST_LOCK_LSB = 0;
  // field positions in the unlock and error threshold register
  localparam int DESC_ERR_MSB = 15;
  localparam int DESC_ERR_LSB = 8;
  localparam int REM_FAIL_MSB = 4;
  localparam int REM_FAIL_LSB = 0;
  // field positions in the transmit interleave register
  localparam int FORCE_ILV_BIT = 2;
  localparam int ILV_EN_BIT = 1;
  localparam int ILV_DET_BIT = 0;
  // jabber timer and test pattern length fields
  localparam int JAB_MSB = 10;
  localparam int JAB_LSB = 0;
  localparam int TP1_MSB = 9;
  localparam int TP1_LSB = 4;

  // status register bit positions
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_REM_OK_BIT = 1;
  localparam int ST_TX_ILV_BIT = 2;
  localparam int ST_JAB_BIT = 3;
  localparam int ST_TP1_BUSY_BIT = 4;
  localparam int ST_ILV_SEEN_BIT = 5;

  // jabber time base: one microsecond in core clock cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int JAB_UNIT_NS = 1000;
  localparam int JAB_UNIT_CYC = JAB_UNIT_NS / CLK_PERIOD_NS;

  // test pattern one: fixed lead of symbols plus twice the field
  localparam logic [6:0] TP1_BASE_SYMS = 7'h02;

  typedef enum logic [0:0] {
    PPL_HUNT,
    PPL_LOCKED
  } ppl_lock_st_t;
endpackage

// ===== shared/ppl_tp_if.sv
// control link between the register bank and the test pattern one generator
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface ppl_tp_if;
  logic start;
  logic [5:0] length;
  logic sym_valid;
  logic sym_plus;
  logic busy;

  modport ctrl (output start, output length, input sym_valid, input sym_plus, input busy);
  modport gen (input start, input length, output sym_valid, output sym_plus, output busy);
endinterface

// ===== src/ppl_tp1_gen.sv
// generator for transmitter test pattern one: alternating +1 / -1 symbols
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module ppl_tp1_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  ppl_tp_if.gen tp
);
  logic [7:0] remain_r;
  logic plus_r;
  logic valid_r;

  // burst counter; a start is taken only when fully idle, last symbol included,
  // so a run is never cut short and busy always tells the truth
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      remain_r <= 8'h00;
    end else if (tp.start && remain_r == 8'h00 && !valid_r) begin
      // eight bits wide: the longest burst is 128 symbols
      remain_r <= 8'(ppl_pkg::TP1_BASE_SYMS) + {1'b0, tp.length, 1'b0};
    end else if (remain_r != 8'h00) begin
      remain_r <= remain_r - 8'h01;
    end
  end

  // symbol polarity starts at +1 and flips every symbol
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      plus_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= remain_r != 8'h00;
      if (remain_r == 8'h00) begin
        plus_r <= 1'b1;
      end else begin
        plus_r <= ~plus_r;
      end
    end
  end

  assign tp.sym_valid = valid_r;
  assign tp.sym_plus = valid_r & ~plus_r;
  assign tp.busy = (remain_r != 8'h00) | valid_r;
endmodule

// ===== src/ppl_pcs_cfg_regs.sv
// pcs link configuration register bank with the logic the fields steer
// assumes all symbol and event inputs come from logic on core_clk
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// - training starts only while link control set
// - force bit marks slave phase one done
// - bit 13 skips lock check in gap
// - lock after first-lock-count idle symbols
// - unlock after error-count non-idle symbols
// - remote status low after threshold error symbols
// - force bit interleaves transmit unconditionally
// - enable bit interleaves only if detected
// - receive interleave detection only while enabled
// - jabber timeout counted in microseconds
// - test pattern sends two plus twice count
module ppl_pcs_cfg_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic train_req,
  input wire logic sym_valid,
  input wire logic sym_idle,
  input wire logic sym_error,
  input wire logic rx_in_ipg,
  input wire logic rx_interleave_seen,
  input wire logic rx_frame_active,
  input wire logic tp1_start,
  output logic train_enable,
  output logic train_start,
  output logic force_slave_first_phase_complete,
  output logic interleave_det_en,
  output logic tx_interleave,
  output logic desc_locked,
  output logic remote_receiver_ok,
  output logic rx_jabber,
  output logic tp1_sym_valid,
  output logic tp1_sym_plus,
  output logic tp1_busy
);
  logic [15:0] train_lock_r;
  logic [15:0] unlock_err_r;
  logic [15:0] tx_ilv_r;
  logic [15:0] jabber_r;
  logic [15:0] test_pat_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] status;
  logic train_start_r;
  ppl_pkg::ppl_lock_st_t lock_st_r;
  logic [8:0] idle_cnt_r;
  logic [7:0] bad_cnt_r;
  logic [4:0] err_cnt_r;
  logic rem_ok_r;
  logic lost_since_lock_r;
  logic ilv_seen_r;
  logic tx_ilv_out_r;
  logic [4:0] us_div_r;
  logic [10:0] us_cnt_r;
  logic jab_r;
  logic [8:0] first_lock_cnt;
  logic [7:0] desc_err_cnt;
  logic [4:0] remote_receiver_fail_threshold;
  logic [10:0] jab_limit;
  logic [5:0] test_pattern_one_length;
  logic gap_check_on;
  logic us_tick;

  ppl_tp_if tp_bus ();

  // field views of the configuration registers
  assign first_lock_cnt = train_lock_r[ppl_pkg::FIRST_LOCK_MSB:ppl_pkg::FIRST_LOCK_LSB];
  assign desc_err_cnt = unlock_err_r[ppl_pkg::DESC_ERR_MSB:ppl_pkg::DESC_ERR_LSB];
  assign remote_receiver_fail_threshold =
    unlock_err_r[ppl_pkg::REM_FAIL_MSB:ppl_pkg::REM_FAIL_LSB];
  assign jab_limit = jabber_r[ppl_pkg::JAB_MSB:ppl_pkg::JAB_LSB];
  assign test_pattern_one_length = test_pat_r[ppl_pkg::TP1_MSB:ppl_pkg::TP1_LSB];

  // register writes; read-only bits are masked so they stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      train_lock_r <= ppl_pkg::RST_TRAIN_LOCK;
      unlock_err_r <= ppl_pkg::RST_UNLOCK_ERR;
      tx_ilv_r <= ppl_pkg::RST_TX_ILV;
      jabber_r <= ppl_pkg::RST_JABBER;
      test_pat_r <= ppl_pkg::RST_TEST_PAT;
    end else if (reg_wr) begin
      case (reg_addr)
        ppl_pkg::ADDR_TRAIN_LOCK: begin
          train_lock_r <= reg_wdata & ppl_pkg::WMASK_TRAIN_LOCK;
        end
        ppl_pkg::ADDR_UNLOCK_ERR: begin
          unlock_err_r <= reg_wdata & ppl_pkg::WMASK_UNLOCK_ERR;
        end
        ppl_pkg::ADDR_TX_ILV: begin
          tx_ilv_r <= reg_wdata & ppl_pkg::WMASK_TX_ILV;
        end
        ppl_pkg::ADDR_JABBER: begin
          jabber_r <= reg_wdata & ppl_pkg::WMASK_JABBER;
        end
        ppl_pkg::ADDR_TEST_PAT: begin
          test_pat_r <= reg_wdata & ppl_pkg::WMASK_TEST_PAT;
        end
        default: begin
        end
      endcase
    end
  end

  // live status word built from the block's own state
  always_comb begin
    status = 16'h0000;
    status[ppl_pkg::ST_LOCK_BIT] = lock_st_r == ppl_pkg::PPL_LOCKED;
    status[ppl_pkg::ST_REM_OK_BIT] = rem_ok_r;
    status[ppl_pkg::ST_TX_ILV_BIT] = tx_ilv_out_r;
    status[ppl_pkg::ST_JAB_BIT] = jab_r;
    status[ppl_pkg::ST_TP1_BUSY_BIT] = tp_bus.busy;
    status[ppl_pkg::ST_ILV_SEEN_BIT] = ilv_seen_r;
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ppl_pkg::ADDR_TRAIN_LOCK: rdata_nxt = train_lock_r;
      ppl_pkg::ADDR_UNLOCK_ERR: rdata_nxt = unlock_err_r;
      ppl_pkg::ADDR_TX_ILV: rdata_nxt = tx_ilv_r;
      ppl_pkg::ADDR_JABBER: rdata_nxt = jabber_r;
      ppl_pkg::ADDR_TEST_PAT: rdata_nxt = test_pat_r;
      ppl_pkg::ADDR_LINK_STATUS: rdata_nxt = status;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // training launch gated by link control
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      train_start_r <= 1'b0;
    end else begin
      train_start_r <= train_req & train_lock_r[ppl_pkg::LINK_CTRL_BIT];
    end
  end

  // gap lock check can be switched off; counters then hold through the gap
  assign gap_check_on = ~(rx_in_ipg & train_lock_r[ppl_pkg::DIS_IPG_LOCK_BIT]);

  // descrambler lock tracking: run of idles to lock, run of non-idles to drop it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_st_r <= ppl_pkg::PPL_HUNT;
      idle_cnt_r <= 9'h000;
      bad_cnt_r <= 8'h00;
    end else if (sym_valid && gap_check_on) begin
      case (lock_st_r)
        ppl_pkg::PPL_HUNT: begin
          bad_cnt_r <= 8'h00;
          if (!sym_idle) begin
            idle_cnt_r <= 9'h000;
          end else if (idle_cnt_r + 9'h001 >= first_lock_cnt) begin
            idle_cnt_r <= 9'h000;
            lock_st_r <= ppl_pkg::PPL_LOCKED;
          end else begin
            idle_cnt_r <= idle_cnt_r + 9'h001;
          end
        end
        ppl_pkg::PPL_LOCKED: begin
          idle_cnt_r <= 9'h000;
          if (sym_idle) begin
            bad_cnt_r <= 8'h00;
          end else if (bad_cnt_r + 8'h01 >= desc_err_cnt) begin
            bad_cnt_r <= 8'h00;
            lock_st_r <= ppl_pkg::PPL_HUNT;
          end else begin
            bad_cnt_r <= bad_cnt_r + 8'h01;
          end
        end
        default: begin
          lock_st_r <= ppl_pkg::PPL_HUNT;
        end
      endcase
    end
  end

  // remote receiver status: raised on lock while link control is set, dropped after enough error symbols
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rem_ok_r <= 1'b0;
      err_cnt_r <= 5'h00;
    end else if (lock_st_r != ppl_pkg::PPL_LOCKED) begin
      rem_ok_r <= 1'b0;
      err_cnt_r <= 5'h00;
    end else if (sym_valid && sym_error && rem_ok_r) begin
      if (err_cnt_r + 5'h01 >= remote_receiver_fail_threshold) begin
        rem_ok_r <= 1'b0;
        err_cnt_r <= 5'h00;
      end else begin
        err_cnt_r <= err_cnt_r + 5'h01;
      end
    end else if (!rem_ok_r && err_cnt_r == 5'h00 && train_lock_r[ppl_pkg::LINK_CTRL_BIT]) begin
      // re-armed only by a fresh lock, so hold low until the next unlock
      rem_ok_r <= ~lost_since_lock_r;
    end
  end

  // remembers that status dropped during the current lock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lost_since_lock_r <= 1'b0;
    end else if (lock_st_r != ppl_pkg::PPL_LOCKED) begin
      lost_since_lock_r <= 1'b0;
    end else if (rem_ok_r && sym_valid && sym_error &&
                 err_cnt_r + 5'h01 >= remote_receiver_fail_threshold) begin
      lost_since_lock_r <= 1'b1;
    end
  end

  // receive interleave detection; clearing the enable forgets what was seen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ilv_seen_r <= 1'b0;
    end else if (!tx_ilv_r[ppl_pkg::ILV_DET_BIT]) begin
      ilv_seen_r <= 1'b0;
    end else if (rx_interleave_seen) begin
      ilv_seen_r <= 1'b1;
    end
  end

  // transmit interleave: force wins, else enable and detection together
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_ilv_out_r <= 1'b0;
    end else begin
      tx_ilv_out_r <= tx_ilv_r[ppl_pkg::FORCE_ILV_BIT] |
                      (tx_ilv_r[ppl_pkg::ILV_EN_BIT] & ilv_seen_r);
    end
  end

  // microsecond prescaler, restarted with each frame
  assign us_tick = us_div_r == 5'(ppl_pkg::JAB_UNIT_CYC - 1);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      us_div_r <= 5'h00;
    end else if (!rx_frame_active || us_tick) begin
      us_div_r <= 5'h00;
    end else begin
      us_div_r <= us_div_r + 5'h01;
    end
  end

  // jabber: frame longer than the limit; holds until the frame ends
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      us_cnt_r <= 11'h000;
      jab_r <= 1'b0;
    end else if (!rx_frame_active) begin
      us_cnt_r <= 11'h000;
      jab_r <= 1'b0;
    end else if (us_tick) begin
      // saturate so a very long frame cannot wrap and release jabber
      if (us_cnt_r != 11'h7ff) begin
        us_cnt_r <= us_cnt_r + 11'h001;
      end
      if (us_cnt_r + 11'h001 >= jab_limit) begin
        jab_r <= 1'b1;
      end
    end
  end

  // test pattern generator hookup
  assign tp_bus.start = tp1_start;
  assign tp_bus.length = test_pattern_one_length;

  ppl_tp1_gen u_tp1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tp(tp_bus)
  );

  // outputs
  assign reg_rdata = rdata_r;
  assign train_enable = train_lock_r[ppl_pkg::LINK_CTRL_BIT];
  assign train_start = train_start_r;
  assign force_slave_first_phase_complete = train_lock_r[ppl_pkg::FORCE_SLAVE_BIT];
  assign interleave_det_en = tx_ilv_r[ppl_pkg::ILV_DET_BIT];
  assign tx_interleave = tx_ilv_out_r;
  assign desc_locked = lock_st_r == ppl_pkg::PPL_LOCKED;
  assign remote_receiver_ok = rem_ok_r;
  assign rx_jabber = jab_r;
  assign tp1_sym_valid = tp_bus.sym_valid;
  assign tp1_sym_plus = tp_bus.sym_plus;
  assign tp1_busy = tp_bus.busy;
endmodule

// ===== tb/ppl_pcs_cfg_regs_assertions.sv
// checker for the pcs link configuration register bank ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module ppl_pcs_cfg_regs_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic train_req,
  input wire logic sym_valid,
  input wire logic sym_idle,
  input wire logic sym_error,
  input wire logic rx_frame_active,
  input wire logic tp1_start,
  input wire logic train_enable,
  input wire logic train_start,
  input wire logic tx_interleave,
  input wire logic desc_locked,
  input wire logic remote_receiver_ok,
  input wire logic rx_jabber,
  input wire logic tp1_sym_valid,
  input wire logic tp1_sym_plus,
  input wire logic tp1_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // two steps of the link watched as named sequences
  sequence jab_quiet;
    !rx_jabber [*8];
  endsequence
  sequence plus_minus;
    tp1_sym_valid && tp1_sym_plus ##1 tp1_sym_valid && !tp1_sym_plus;
  endsequence
  logic ilv_wr;
  // write to the interleave register
  assign ilv_wr = reg_wr && (reg_addr == ppl_pkg::ADDR_TX_ILV);

  chk_train_gate: assert property (1'b1 |=> train_start == $past(train_req && train_enable))
    else $error("train start not gated by link control");
  chk_ilv_force: assert property (ilv_wr && reg_wdata[2] |-> ##2 tx_interleave)
    else $error("forced interleave missing");
  chk_ilv_off: assert property (ilv_wr && reg_wdata[2:1] == 2'b00 |-> ##2 !tx_interleave)
    else $error("interleave on while disabled");
  chk_lock_idle: assert property ($rose(desc_locked) |-> $past(sym_valid && sym_idle))
    else $error("lock without idle symbol");
  chk_unlock_busy: assert property ($fell(desc_locked) |-> $past(sym_valid && !sym_idle))
    else $error("unlock without non-idle symbol");
  chk_remote_drop: assert property ($fell(remote_receiver_ok) && desc_locked
    |-> $past(sym_valid && sym_error))
    else $error("remote status dropped without error");
  chk_jab_start: assert property ($rose(rx_frame_active) |-> jab_quiet)
    else $error("jabber too early");
  chk_jab_clear: assert property (!rx_frame_active |=> !rx_jabber)
    else $error("jabber outside frame");
  chk_tp_first: assert property (tp1_start && !tp1_busy
    |-> ##2 tp1_sym_valid && tp1_sym_plus)
    else $error("pattern does not open with plus");
  chk_tp_pairs: assert property (tp1_sym_valid && tp1_sym_plus |-> plus_minus)
    else $error("pattern symbols not paired");
endmodule

bind ppl_pcs_cfg_regs ppl_pcs_cfg_regs_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .train_req(train_req),
  .sym_valid(sym_valid), .sym_idle(sym_idle), .sym_error(sym_error),
  .rx_frame_active(rx_frame_active), .tp1_start(tp1_start), .train_enable(train_enable),
  .train_start(train_start), .tx_interleave(tx_interleave), .desc_locked(desc_locked),
  .remote_receiver_ok(remote_receiver_ok), .rx_jabber(rx_jabber),
  .tp1_sym_valid(tp1_sym_valid), .tp1_sym_plus(tp1_sym_plus), .tp1_busy(tp1_busy));

// ===== tb/ppl_link_partner.sv
// remote link partner: symbol stream by mode
// assumes mode changes right after a rising edge; 0 quiet, 1 idle, 2 data, 3 error
`timescale 1ns/1ps
module ppl_link_partner (
  input wire logic core_clk,
  input wire logic [1:0] mode,
  output logic sym_valid,
  output logic sym_idle,
  output logic sym_error
);
  logic tog_r = 1'b0;
  // toggling pattern so a quiet line never shows a stale symbol kind
  always @(posedge core_clk) begin
    tog_r <= ~tog_r;
  end
  // symbol kind from mode
  assign sym_valid = (mode != 2'd0);
  assign sym_idle = (mode == 2'd0) ? tog_r : (mode == 2'd1);
  assign sym_error = (mode == 2'd0) ? ~tog_r : (mode == 2'd3);
endmodule

// ===== tb/tb_ppl_pcs_cfg_regs.sv
// testbench for the pcs link configuration register bank
// assumes the partner model drives the symbol inputs
`timescale 1ns/1ps
module tb_ppl_pcs_cfg_regs;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, train_req = 1'b0, rx_in_ipg = 1'b0, tp1_start = 1'b0;
  logic rx_interleave_seen = 1'b0, rx_frame_active = 1'b0;
  logic [1:0] mode = 2'd0;
  logic [15:0] reg_rdata;
  logic sym_valid, sym_idle, sym_error, train_enable, train_start;
  logic force_slave_first_phase_complete;
  logic interleave_det_en, tx_interleave, desc_locked, remote_receiver_ok, rx_jabber;
  logic tp1_sym_valid, tp1_sym_plus, tp1_busy;
  int failures = 0, total_checks = 0, cycles = 0, nv, np, nb;
  logic [11:0] ra [6] = '{12'h485, 12'h486, 12'h489, 12'h496, 12'h497, 12'h400};
  logic [15:0] rv [6] = '{16'h1078, 16'h0a05, 16'h0001, 16'h044c, 16'h01c0, 16'h0000};
  logic [15:0] rm [6] = '{16'h71ff, 16'hff1f, 16'h0007, 16'h07ff, 16'h03f0, 16'h0000};

  ppl_pcs_cfg_regs u_ppl_pcs_cfg_regs (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .train_req(train_req), .sym_valid(sym_valid), .sym_idle(sym_idle), .sym_error(sym_error),
    .rx_in_ipg(rx_in_ipg), .rx_interleave_seen(rx_interleave_seen),
    .rx_frame_active(rx_frame_active), .tp1_start(tp1_start), .train_enable(train_enable),
    .train_start(train_start), .force_slave_first_phase_complete(force_slave_first_phase_complete),
    .interleave_det_en(interleave_det_en), .tx_interleave(tx_interleave),
    .desc_locked(desc_locked), .remote_receiver_ok(remote_receiver_ok), .rx_jabber(rx_jabber),
    .tp1_sym_valid(tp1_sym_valid), .tp1_sym_plus(tp1_sym_plus), .tp1_busy(tp1_busy));
  ppl_link_partner u_ppl_link_partner (.core_clk(core_clk), .mode(mode), .sym_valid(sym_valid),
    .sym_idle(sym_idle), .sym_error(sym_error));

  // clock, 50 ns period
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "read");
  endtask
  task automatic req_train(input logic exp);
    @(posedge core_clk);
    train_req <= 1'b1;
    @(posedge core_clk);
    train_req <= 1'b0;
    #1;
    chk(16'(train_start), 16'(exp), "train start");
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  // main sequence
  initial begin
    tick(2);
    rst_n <= 1'b1;
    chk(16'(train_enable), 16'h0001, "link ctrl reset");
    chk(16'(interleave_det_en), 16'h0001, "det reset");
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], rv[i]);
      wr(ra[i], 16'hffff);
      rd(ra[i], rm[i]);
      wr(ra[i], rv[i]);
    end
    fin("registers");
    req_train(1'b1);
    wr(12'h485, 16'h0078);
    req_train(1'b0);
    wr(12'h485, 16'h7003);
    tick(1);
    chk(16'(force_slave_first_phase_complete), 16'h0001, "force slave");
    fin("training");
    @(posedge core_clk);
    rx_in_ipg <= 1'b1;
    mode <= 2'd1;
    tick(6);
    chk(16'(desc_locked), 16'h0000, "gap lock check");
    @(posedge core_clk);
    rx_in_ipg <= 1'b0;
    tick(2);
    chk(16'(desc_locked), 16'h0000, "early lock");
    tick(1);
    chk(16'(desc_locked), 16'h0001, "lock");
    tick(1);
    chk(16'(remote_receiver_ok), 16'h0001, "remote ok");
    wr(12'h486, 16'h0802);
    @(posedge core_clk);
    mode <= 2'd3;
    tick(1);
    chk(16'(remote_receiver_ok), 16'h0001, "remote one error");
    tick(2);
    chk(16'(remote_receiver_ok), 16'h0000, "remote drop");
    @(posedge core_clk);
    mode <= 2'd1;
    @(posedge core_clk);
    mode <= 2'd2;
    tick(7);
    chk(16'(desc_locked), 16'h0001, "early unlock");
    tick(1);
    chk(16'(desc_locked), 16'h0000, "unlock");
    mode <= 2'd0;
    fin("lock");
    wr(12'h489, 16'h0004);
    tick(2);
    chk(16'(tx_interleave), 16'h0001, "force ilv");
    wr(12'h489, 16'h0003);
    tick(2);
    chk(16'(tx_interleave), 16'h0000, "ilv unseen");
    rx_interleave_seen <= 1'b1;
    tick(3);
    chk(16'(tx_interleave), 16'h0001, "ilv seen");
    // status word: transmit interleave and interleave seen set, all else clear
    rd(12'h498, 16'h0024);
    rx_interleave_seen <= 1'b0;
    wr(12'h489, 16'h0002);
    tick(3);
    chk(16'({interleave_det_en, tx_interleave}), 16'h0000, "det off");
    wr(12'h489, 16'h0001);
    fin("interleave");
    for (int l = 1; l < 3; l++) begin
      wr(12'h496, 16'(l));
      @(posedge core_clk);
      rx_frame_active <= 1'b1;
      tick(20 * l - 2);
      chk(16'(rx_jabber), 16'h0000, "jabber early");
      tick(3);
      chk(16'(rx_jabber), 16'h0001, "jabber");
      rx_frame_active <= 1'b0;
      tick(2);
      chk(16'(rx_jabber), 16'h0000, "jabber clear");
    end
    fin("jabber");
    // lengths 0, 3 and the largest field value 63
    for (int n = 0; n < 64; n += (n == 0) ? 3 : 60) begin
      wr(12'h497, 16'(n << 4));
      nv = 0;
      np = 0;
      nb = 0;
      @(posedge core_clk);
      tp1_start <= 1'b1;
      // a second start inside the burst must be ignored
      for (int k = 0; k < 2 * n + 8; k++) begin
        @(posedge core_clk);
        tp1_start <= (k == 2);
        #1;
        nb += (tp1_busy === 1'b1);
        if (tp1_sym_valid === 1'b1) begin
          np += (tp1_sym_plus !== ((nv % 2) == 0));
          nv++;
        end
      end
      chk(16'(nv), 16'(2 + 2 * n), "pattern length");
      chk(16'(np), 16'h0000, "pattern order");
      chk(16'(nb), 16'(3 + 2 * n), "pattern busy");
    end
    fin("pattern");
    conclude();
  end
endmodule
